// ### logic/pdm_port.sv
`default_nettype none
`include "pdm_regs.svh"
module pdm_port #(
	parameter logic [`PDM_NPINS-1:0] SPECIAL_PINS = 8'h00
) (
	// clock and reset
	input  wire logic                        clk_i,
	input  wire logic                        rst_i,
	// wishbone slave
	input  wire pdm_pkg::pdm_wb_req_type     wb_i,
	output logic                             wb_ack_o,
	output logic [`PDM_DAT_W-1:0]            wb_dat_o,
	// pads
	input  wire logic [`PDM_NPINS-1:0]       pad_i,
	output logic [`PDM_NPINS-1:0]            pad_o,
	output logic [`PDM_NPINS-1:0]            pad_oe_n_o,
	output logic [`PDM_NPINS-1:0]            pad_res_o,
	output logic [`PDM_NPINS-1:0]            pad_slow_o,
	output logic [`PDM_NPINS-1:0]            inbuf_en_o,
	// digital routing
	input  wire logic [`PDM_NPINS-1:0]       route_i,
	output logic [`PDM_NPINS-1:0]            route_o,
	// port interrupt
	output logic                             irq_o
);
	pdm_pkg::pdm_state_type s_reg;
	pdm_pkg::pdm_state_type s_next;

	// ****************************************************************
	// helpers
	// ****************************************************************
	// assemble the mode code of one pin from the three planes
	function automatic logic [2:0] pin_mode(input pdm_pkg::pdm_state_type s, input int n);
		pin_mode = {s.dm2[n], s.dm1[n], s.dm0[n]};
	endfunction : pin_mode

	// driver decision from mode, data bit and regulated flag
	function automatic pdm_pkg::pdm_drive_type drive(input logic [2:0] m, input logic d,
		input logic regu);
		pdm_pkg::pdm_drive_type r;
		r = '{val: d, oe_n: 1'b1, res: 1'b0};
		case (m)
			`PDM_DM_ANA, `PDM_DM_HIZ: r.oe_n = 1'b1;
			`PDM_DM_RES_UP: begin
				r.oe_n = 1'b0;
				r.res  = d;
			end
			`PDM_DM_RES_DN: begin
				r.oe_n = 1'b0;
				r.res  = ~d;
			end
			`PDM_DM_OD_LO: r.oe_n = d;
			`PDM_DM_OD_HI: r.oe_n = ~d;
			`PDM_DM_STRONG: r.oe_n = 1'b0;
			`PDM_DM_RES_UD: begin
				r.oe_n = 1'b0;
				r.res  = 1'b1;
			end
			default: r.oe_n = 1'b1;
		endcase
		// regulated special pins cannot pull resistively, so the weak half floats
		if (regu && r.res) begin
			r.oe_n = 1'b1;
		end
		drive = r;
	endfunction : drive

	// pin-form word of one pin
	function automatic logic [`PDM_DAT_W-1:0] pin_word(input pdm_pkg::pdm_state_type s,
		input int n, input logic st);
		logic [`PDM_DAT_W-1:0] w;
		w = '0;
		w[`PDM_PF_OUT] = s.out[n];
		w[`PDM_PF_DM_HI:`PDM_PF_DM_LO] = pin_mode(s, n);
		w[`PDM_PF_BYP] = s.byp[n];
		w[`PDM_PF_SLOW] = s.slow[n];
		w[`PDM_PF_RISE] = s.rise[n];
		w[`PDM_PF_FALL] = s.fall[n];
		w[`PDM_PF_STATE] = st;
		pin_word = w;
	endfunction : pin_word

	// ****************************************************************
	// next state
	// ****************************************************************
	logic                  req;
	logic                  wr;
	logic                  rd;
	logic                  pin_hit;
	logic [2:0]            pin_idx;
	logic [`PDM_ADR_W-1:0] pin_ofs;
	logic [`PDM_NPINS-1:0] inbuf;
	logic [`PDM_NPINS-1:0] ival;
	logic [`PDM_NPINS-1:0] ev;
	logic [`PDM_NPINS-1:0] src;
	logic [7:0]            wbyte;
	logic [2:0]            wmode;
	pdm_pkg::pdm_drive_type dd;

	always_comb begin
		s_next = s_reg;
		req = wb_i.cyc & wb_i.stb & ~s_reg.ack;
		wr = req & wb_i.we & wb_i.sel[0];
		rd = req & ~wb_i.we;
		wbyte = wb_i.dat[7:0];
		wmode = wb_i.dat[`PDM_PF_DM_HI:`PDM_PF_DM_LO];
		pin_ofs = wb_i.adr - `PDM_OFS_PIN0;
		pin_idx = pin_ofs[4:2];
		pin_hit = (wb_i.adr >= `PDM_OFS_PIN0) && (wb_i.adr <= `PDM_OFS_PIN7)
			&& (wb_i.adr[1:0] == 2'h0);
		// single-cycle answer, dropped the cycle after
		s_next.ack = req;
		// two-stage input capture; only sync2 looks at sync1
		s_next.sync1 = pad_i;
		s_next.sync2 = s_reg.sync1;
		// analog pins have their input buffer off and read as zero
		for (int n = 0; n < `PDM_NPINS; n++) begin
			inbuf[n] = pin_mode(s_reg, n) != `PDM_DM_ANA;
		end
		ival = s_reg.sync2 & inbuf;
		s_next.prev = ival;
		// edges only: level detection is left to the routing fabric
		ev = (ival & ~s_reg.prev & s_reg.rise) | (~ival & s_reg.prev & s_reg.fall);
		// register writes
		if (wr) begin
			case (wb_i.adr)
				`PDM_OFS_OUT:  s_next.out = wbyte;
				`PDM_OFS_DM0:  s_next.dm0 = wbyte;
				`PDM_OFS_DM1:  s_next.dm1 = wbyte;
				`PDM_OFS_DM2:  s_next.dm2 = wbyte;
				`PDM_OFS_BYP:  s_next.byp = wbyte;
				`PDM_OFS_SLOW: s_next.slow = wbyte;
				`PDM_OFS_REGU: s_next.regu = wbyte & SPECIAL_PINS;
				`PDM_OFS_RISE: s_next.rise = wbyte;
				`PDM_OFS_FALL: s_next.fall = wbyte;
				`PDM_OFS_MASK: s_next.mask = wbyte;
				default: begin
					if (pin_hit) begin
						s_next.out[pin_idx] = wb_i.dat[`PDM_PF_OUT];
						s_next.dm0[pin_idx] = wmode[0];
						s_next.dm1[pin_idx] = wmode[1];
						s_next.dm2[pin_idx] = wmode[2];
						s_next.byp[pin_idx] = wb_i.dat[`PDM_PF_BYP];
						s_next.slow[pin_idx] = wb_i.dat[`PDM_PF_SLOW];
						s_next.rise[pin_idx] = wb_i.dat[`PDM_PF_RISE];
						s_next.fall[pin_idx] = wb_i.dat[`PDM_PF_FALL];
					end
				end
			endcase
		end
		// read data; unmapped addresses answer zero
		s_next.rdat = '0;
		if (rd) begin
			case (wb_i.adr)
				`PDM_OFS_OUT:   s_next.rdat[7:0] = s_reg.out;
				`PDM_OFS_STATE: s_next.rdat[7:0] = ival;
				`PDM_OFS_DM0:   s_next.rdat[7:0] = s_reg.dm0;
				`PDM_OFS_DM1:   s_next.rdat[7:0] = s_reg.dm1;
				`PDM_OFS_DM2:   s_next.rdat[7:0] = s_reg.dm2;
				`PDM_OFS_BYP:   s_next.rdat[7:0] = s_reg.byp;
				`PDM_OFS_SLOW:  s_next.rdat[7:0] = s_reg.slow;
				`PDM_OFS_REGU:  s_next.rdat[7:0] = s_reg.regu;
				`PDM_OFS_RISE:  s_next.rdat[7:0] = s_reg.rise;
				`PDM_OFS_FALL:  s_next.rdat[7:0] = s_reg.fall;
				`PDM_OFS_STAT:  s_next.rdat[7:0] = s_reg.stat;
				`PDM_OFS_MASK:  s_next.rdat[7:0] = s_reg.mask;
				default: begin
					if (pin_hit) begin
						s_next.rdat = pin_word(s_reg, 32'(pin_idx), ival[pin_idx]);
					end
				end
			endcase
		end
		// read clears status, but a new edge in the same cycle survives
		if (rd && (wb_i.adr == `PDM_OFS_STAT)) begin
			s_next.stat = '0;
		end
		s_next.stat = s_next.stat | ev;
		// pad drivers, registered so the pins never glitch
		for (int n = 0; n < `PDM_NPINS; n++) begin
			src[n] = s_reg.byp[n] ? route_i[n] : s_reg.out[n];
			dd = drive(pin_mode(s_reg, n), src[n], s_reg.regu[n] & SPECIAL_PINS[n]);
			s_next.pad_val[n] = dd.val;
			s_next.pad_oe_n[n] = dd.oe_n;
			s_next.pad_res[n] = dd.res & ~dd.oe_n;
			// slew control has no meaning for resistive drive
			s_next.pad_slow[n] = s_reg.slow[n] & ~dd.res;
		end
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_reg <= '0;
			s_reg.pad_oe_n <= `PDM_RST_OE_N;
		end else begin
			s_reg <= s_next;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	always_comb begin
		for (int n = 0; n < `PDM_NPINS; n++) begin
			inbuf_en_o[n] = pin_mode(s_reg, n) != `PDM_DM_ANA;
		end
	end
	assign wb_ack_o   = s_reg.ack;
	assign wb_dat_o   = s_reg.rdat;
	assign pad_o      = s_reg.pad_val;
	assign pad_oe_n_o = s_reg.pad_oe_n;
	assign pad_res_o  = s_reg.pad_res;
	assign pad_slow_o = s_reg.pad_slow;
	assign route_o    = s_reg.prev;
	// one level request for the whole port
	assign irq_o      = |(s_reg.stat & s_reg.mask);

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	logic [2:0] m0;
	assign m0 = pin_mode(s_reg, 0);

	// reset checks must run while reset is high, so they opt out of the default disable
	reset_float_a: assert property (disable iff (1'b0) rst_i |=> pad_oe_n_o == `PDM_RST_OE_N
		&& inbuf_en_o == 8'h00 && !irq_o)
		else $error("pins not floating after reset");
	analog_input_a: assert property (m0 == `PDM_DM_ANA [*3] |-> !route_o[0])
		else $error("analog pin shows digital input");
	// each drive check watches a pin that the bench actually puts in that mode
	hiz_float_a: assert property (pin_mode(s_reg, 2) == `PDM_DM_HIZ |=> pad_oe_n_o[2])
		else $error("digital hiz pin driven");
	strong_drive_a: assert property (pin_mode(s_reg, 4) == `PDM_DM_STRONG && !s_reg.byp[4]
		|=> !pad_oe_n_o[4] && pad_o[4] == $past(s_reg.out[4]) && !pad_res_o[4])
		else $error("strong drive wrong");
	od_low_a: assert property (m0 == `PDM_DM_OD_LO && !s_reg.byp[0]
		|=> pad_oe_n_o[0] == $past(s_reg.out[0]))
		else $error("open drain low wrong");
	od_high_a: assert property (pin_mode(s_reg, 3) == `PDM_DM_OD_HI && !s_reg.byp[3]
		|=> pad_oe_n_o[3] == !$past(s_reg.out[3]))
		else $error("open drain high wrong");
	bypass_src_a: assert property (pin_mode(s_reg, 1) == `PDM_DM_STRONG && s_reg.byp[1]
		|=> pad_o[1] == $past(route_i[1]))
		else $error("bypass not taken from routing");
	// resistive modes, only where the pin is not a regulated special pin
	res_up_a: assert property (pin_mode(s_reg, 5) == `PDM_DM_RES_UP && !s_reg.byp[5]
		&& !s_reg.regu[5] |=> !pad_oe_n_o[5] && pad_res_o[5] == $past(s_reg.out[5]))
		else $error("resistive pull up wrong");
	res_down_a: assert property (pin_mode(s_reg, 6) == `PDM_DM_RES_DN && !s_reg.byp[6]
		&& !s_reg.regu[6] |=> !pad_oe_n_o[6] && pad_res_o[6] == !$past(s_reg.out[6]))
		else $error("resistive pull down wrong");
	res_both_a: assert property (pin_mode(s_reg, 7) == `PDM_DM_RES_UD && !s_reg.regu[7]
		|=> !pad_oe_n_o[7] && pad_res_o[7])
		else $error("resistive up down wrong");
	// a regulated special pin never ends up on a series resistor
	regu_weak_a: assert property (1'b1 |=> (pad_res_o & $past(s_reg.regu)) == 8'h00)
		else $error("regulated pin drives resistively");
	slow_strong_a: assert property (s_reg.slow[4] && pin_mode(s_reg, 4) == `PDM_DM_STRONG
		|=> pad_slow_o[4])
		else $error("slow slew not applied");
	// a pin-form write to pin 2 lands in the mode planes of that pin
	pin_write_a: assert property (wr && pin_hit && pin_idx == 3'h2
		|=> pin_mode(s_reg, 2) == $past(wmode))
		else $error("pin form mode write lost");
	state_read_a: assert property (rd && wb_i.adr == `PDM_OFS_STATE
		|=> s_reg.out == $past(s_reg.out))
		else $error("pin state read disturbed latch");
	edge_status_a: assert property (pin_mode(s_reg, 2) != `PDM_DM_ANA && s_reg.rise[2]
		&& s_reg.mask[2] && s_reg.sync2[2] && !s_reg.prev[2]
		|=> s_reg.stat[2] && irq_o)
		else $error("rising edge not flagged");
	fall_status_a: assert property (pin_mode(s_reg, 2) != `PDM_DM_ANA && s_reg.fall[2]
		&& !s_reg.sync2[2] && s_reg.prev[2] |=> s_reg.stat[2])
		else $error("falling edge not flagged");
	// the clear loses against an edge in the same cycle
	clear_status_a: assert property (rd && wb_i.adr == `PDM_OFS_STAT && !ev[2]
		|=> !s_reg.stat[2])
		else $error("status not cleared by read");
	sync_depth_a: assert property (pad_i[3] && pin_mode(s_reg, 3) != `PDM_DM_ANA
		##1 pin_mode(s_reg, 3) != `PDM_DM_ANA ##1 pin_mode(s_reg, 3) != `PDM_DM_ANA
		|=> route_o[3] == $past(pad_i[3], 3))
		else $error("input path depth wrong");
	ack_answer_a: assert property (req |=> wb_ack_o)
		else $error("request not answered");
	ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held for two cycles");
endmodule : pdm_port
`default_nettype wire

// ### logic/pdm_regs.svh
`ifndef PDM_REGS_SVH
`define PDM_REGS_SVH
// ****************************************************************
// port geometry and bus width
// ****************************************************************
`define PDM_NPINS      8
`define PDM_ADR_W      8
`define PDM_DAT_W      32
// ****************************************************************
// port-form register offsets, one bit per pin
// ****************************************************************
`define PDM_OFS_OUT    8'h00
`define PDM_OFS_STATE  8'h04
`define PDM_OFS_DM0    8'h08
`define PDM_OFS_DM1    8'h0c
`define PDM_OFS_DM2    8'h10
`define PDM_OFS_BYP    8'h14
`define PDM_OFS_SLOW   8'h18
`define PDM_OFS_REGU   8'h1c
`define PDM_OFS_RISE   8'h20
`define PDM_OFS_FALL   8'h24
`define PDM_OFS_STAT   8'h28
`define PDM_OFS_MASK   8'h2c
// ****************************************************************
// pin-form registers, one word per pin
// ****************************************************************
`define PDM_OFS_PIN0   8'h40
`define PDM_OFS_PIN7   8'h5c
`define PDM_PF_OUT     0
`define PDM_PF_DM_LO   1
`define PDM_PF_DM_HI   3
`define PDM_PF_BYP     4
`define PDM_PF_SLOW    5
`define PDM_PF_RISE    6
`define PDM_PF_FALL    7
`define PDM_PF_STATE   8
// ****************************************************************
// drive mode codes
// ****************************************************************
`define PDM_DM_ANA     3'h0
`define PDM_DM_HIZ     3'h1
`define PDM_DM_RES_UP  3'h2
`define PDM_DM_RES_DN  3'h3
`define PDM_DM_OD_LO   3'h4
`define PDM_DM_OD_HI   3'h5
`define PDM_DM_STRONG  3'h6
`define PDM_DM_RES_UD  3'h7
// ****************************************************************
// reset values
// ****************************************************************
`define PDM_RST_PLANE  8'h00
`define PDM_RST_OE_N   8'hff
`endif

// ### logic/pdm_pkg.sv
`default_nettype none
`include "pdm_regs.svh"
package pdm_pkg;
	typedef logic [`PDM_NPINS-1:0] pdm_plane_type;
	// ****************************************************************
	// wishbone request from the master
	// ****************************************************************
	typedef struct packed {
		logic                  cyc;
		logic                  stb;
		logic                  we;
		logic [3:0]            sel;
		logic [`PDM_ADR_W-1:0] adr;
		logic [`PDM_DAT_W-1:0] dat;
	} pdm_wb_req_type;
	// driver decision for one pin
	typedef struct packed {
		logic val;
		logic oe_n;
		logic res;
	} pdm_drive_type;
	// ****************************************************************
	// whole state of the port
	// ****************************************************************
	typedef struct packed {
		pdm_plane_type         out;
		pdm_plane_type         dm0;
		pdm_plane_type         dm1;
		pdm_plane_type         dm2;
		pdm_plane_type         byp;
		pdm_plane_type         slow;
		pdm_plane_type         regu;
		pdm_plane_type         rise;
		pdm_plane_type         fall;
		pdm_plane_type         stat;
		pdm_plane_type         mask;
		pdm_plane_type         sync1;
		pdm_plane_type         sync2;
		pdm_plane_type         prev;
		pdm_plane_type         pad_val;
		pdm_plane_type         pad_oe_n;
		pdm_plane_type         pad_res;
		pdm_plane_type         pad_slow;
		logic                  ack;
		logic [`PDM_DAT_W-1:0] rdat;
	} pdm_state_type;
endpackage : pdm_pkg
`default_nettype wire

// ### tb/pdm_board.sv
`default_nettype none
// ****************************************************************
// board side of the eight pins
// ****************************************************************
module pdm_board (
	// clock
	input  wire logic       clk_i,
	// design side of the pins
	input  wire logic [7:0] pad_o_i,
	input  wire logic [7:0] oe_n_i,
	input  wire logic [7:0] res_i,
	// board drivers
	input  wire logic [7:0] ext_en_i,
	input  wire logic [7:0] ext_val_i,
	// resolved pin level
	output logic      [7:0] level_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] float_reg = 8'h55;
	// undriven pins wander, so a stale level never passes for a real one
	always @(posedge clk_i) begin
		float_reg <= ~float_reg;
	end
	// strong drive beats the board, the board beats a series resistor
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			level_o[i] = (!oe_n_i[i] && !res_i[i]) ? pad_o_i[i] :
				ext_en_i[i] ? ext_val_i[i] :
				!oe_n_i[i] ? pad_o_i[i] : float_reg[i];
		end
	end
endmodule : pdm_board
`default_nettype wire

// ### tb/tb.sv
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************************************
	// clock, design and board
	// ****************************************************************
	logic                    clk_i = 1'b0;
	logic                    rst_i = 1'b1;
	pdm_pkg::pdm_wb_req_type wb_i = '0;
	logic                    wb_ack_o;
	logic [31:0]             wb_dat_o;
	logic [7:0]              pad_i, pad_o, pad_oe_n_o, pad_res_o, pad_slow_o;
	logic [7:0]              inbuf_en_o, route_o;
	logic [7:0]              route_i = 8'h00;
	logic [7:0]              ext_en = 8'h05;
	logic [7:0]              ext_val = 8'h00;
	logic                    irq_o;
	logic [31:0]             rd;
	int                      mismatches = 0;
	int                      checked = 0;
	int                      n, p;
	// index {mode, data} gives {oe_n, val, res, inbuf}
	localparam logic [3:0] ROWS [16] = '{4'h8, 4'h8, 4'h9, 4'h9, 4'h1, 4'h7, 4'h3, 4'h5,
		4'h1, 4'h9, 4'h9, 4'h5, 4'h1, 4'h5, 4'h3, 4'h7};
	always #10 clk_i = ~clk_i;
	// pin 7 is a special pin so the regulated mode has something to act on
	pdm_port #(.SPECIAL_PINS(8'h80)) i_pdm_port (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i),
		.wb_ack_o(wb_ack_o),
		.wb_dat_o(wb_dat_o), .pad_i(pad_i), .pad_o(pad_o), .pad_oe_n_o(pad_oe_n_o),
		.pad_res_o(pad_res_o), .pad_slow_o(pad_slow_o), .inbuf_en_o(inbuf_en_o),
		.route_i(route_i), .route_o(route_o), .irq_o(irq_o));
	pdm_board i_pdm_board (.clk_i(clk_i), .pad_o_i(pad_o), .oe_n_i(pad_oe_n_o),
		.res_i(pad_res_o), .ext_en_i(ext_en), .ext_val_i(ext_val), .level_o(pad_i));
	// ****************************************************************
	// shared tasks
	// ****************************************************************
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
		checked++;
		if (seen !== want) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, want, seen);
		end
	endtask : check
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_of_test
	// one classic cycle; waits for ack under a bound, read data lands in rd
	task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int k = 0;
		@(posedge clk_i);
		wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: adr, dat: dat};
		do begin
			@(posedge clk_i);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 20);
		rd = wb_dat_o;
		wb_i <= '0;
		if (wb_ack_o !== 1'b1) begin
			mismatches++;
			end_of_test();
		end
	endtask : xfer
	// hang guard
	initial begin
		repeat (5000) @(posedge clk_i);
		mismatches++;
		end_of_test();
	end
	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		check("oe_n after reset", pad_oe_n_o, 8'hff);
		check("inbuf after reset", inbuf_en_o, 8'h00);
		check("irq after reset", irq_o, 1'b0);
		$display("test reset done");
		// every mode and data value, spread over all pins through pin form
		for (int r = 0; r < 16; r++) begin
			xfer(1'b1, 8'h40 + 8'(4 * (r % 8)), 32'(r));
			repeat (2) @(posedge clk_i);
			p = r % 8;
			check("drive", {pad_oe_n_o[p], ~pad_oe_n_o[p] & pad_o[p],
				~pad_oe_n_o[p] & pad_res_o[p], inbuf_en_o[p]}, 32'(ROWS[r]));
		end
		$display("test drive table done");
		// bypass on pin 1, strong, latch bit left zero
		xfer(1'b1, 8'h44, 32'h1c);
		route_i <= 8'h02;
		repeat (3) @(posedge clk_i);
		check("bypass high", pad_o[1], 1'b1);
		route_i <= 8'h00;
		repeat (3) @(posedge clk_i);
		check("bypass low", pad_o[1], 1'b0);
		$display("test bypass done");
		// pin 0 back to analog while the board pulls it high
		xfer(1'b1, 8'h40, 32'h00);
		ext_val <= 8'h01;
		repeat (6) @(posedge clk_i);
		xfer(1'b0, 8'h04, 32'h0);
		check("pin state", rd & 32'h9, 32'h8);
		check("route analog pin", route_o[0], 1'b0);
		xfer(1'b0, 8'h00, 32'h0);
		check("output latch", rd, 32'ha8);
		xfer(1'b0, 8'h10, 32'h0);
		check("mode bit 2 plane", rd, 32'hfe);
		xfer(1'b0, 8'h58, 32'h0);
		check("pin 6 word", rd, 32'h0e);
		$display("test registers done");
		// rising edge on pin 2, unmasked
		xfer(1'b1, 8'h48, 32'h42);
		xfer(1'b1, 8'h2c, 32'h04);
		xfer(1'b0, 8'h28, 32'h0);
		ext_val <= 8'h05;
		for (n = 0; n < 10 && irq_o !== 1'b1; n++) @(posedge clk_i);
		check("irq raised", irq_o, 1'b1);
		xfer(1'b0, 8'h28, 32'h0);
		check("status", rd, 32'h04);
		xfer(1'b0, 8'h28, 32'h0);
		check("status cleared", rd, 32'h0);
		check("irq cleared", irq_o, 1'b0);
		// falling edge on pin 2, masked: status sticks, line stays low
		xfer(1'b1, 8'h48, 32'h82);
		xfer(1'b1, 8'h2c, 32'h00);
		ext_val <= 8'h01;
		repeat (6) @(posedge clk_i);
		check("masked irq", irq_o, 1'b0);
		xfer(1'b0, 8'h28, 32'h0);
		check("fall status", rd, 32'h04);
		xfer(1'b0, 8'h80, 32'h0);
		check("unmapped read", rd, 32'h0);
		$display("test interrupts done");
		// regulated special pin floats its resistive half; slow slew dropped on resistive drive
		xfer(1'b1, 8'h1c, 32'hc0);
		xfer(1'b0, 8'h1c, 32'h0);
		check("regulated pins", rd, 32'h80);
		xfer(1'b1, 8'h18, 32'h50);
		repeat (2) @(posedge clk_i);
		check("regulated float", pad_oe_n_o[7:6], 2'b10);
		check("slow slew", pad_slow_o, 8'h10);
		$display("test options done");
		// reset in mid-run brings every pin back to analog
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		check("oe_n mid reset", pad_oe_n_o, 8'hff);
		check("inbuf mid reset", inbuf_en_o, 8'h00);
		check("slow mid reset", pad_slow_o, 8'h00);
		xfer(1'b0, 8'h10, 32'h0);
		check("modes cleared", rd, 32'h0);
		$display("test mid reset done");
		end_of_test();
	end
endmodule : tb
`default_nettype wire
